// ### bench/port_ctrl_checker.sv
/*
  Port-level assertions for the port direction and pull-up block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/10ps
module port_ctrl_checker (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [7:0] regRdata,
  input wire logic [7:0] port0OutEn,
  input wire logic [7:0] port0PullEn,
  input wire logic [7:0] port2OutEn,
  input wire logic [7:0] port2PullEn,
  input wire logic [7:0] port2Gpio,
  input wire logic [7:0] port3Gpio
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Pin-level relations between registers, grants and enables, and the read data slot
  chk_p03_no_out: assert property (port0OutEn[3] == 1'b0)
    else $error("input-only pin driven");
  chk_p03_no_pull: assert property (port0PullEn[3] == 1'b0)
    else $error("input-only pin pulled");
  chk_pull_input: assert property (
    (port2PullEn & port2OutEn) == 8'h00)
    else $error("pull-up on output pin");
  chk_seg_none: assert property (port2Gpio == 8'h00 |->
    port2OutEn == 8'h00 && port2PullEn == 8'h00)
    else $error("ungranted pin enabled");
  chk_rdata_slot: assert property (
    regRdata != 8'h00 |-> $past(regRd))
    else $error("read data outside its slot");
  chk_dir_write: assert property (regWr && regAddr == 8'hc2
    ##1 port2Gpio == 8'hff |-> port2OutEn == $past(regWdata))
    else $error("direction write not applied");
  chk_pull_write: assert property (regWr && regAddr == 8'he2 |=>
    port2PullEn == ($past(regWdata) & ~port2OutEn & port2Gpio))
    else $error("pull-up write not applied");
  chk_share_all: assert property (regWr && regAddr == 8'hc8 &&
    regWdata[2:0] == 3'h4 |=> port2Gpio == 8'hff && port3Gpio == 8'hff)
    else $error("full share grant wrong");
  chk_share_low: assert property (regWr && regAddr == 8'hc8 &&
    regWdata[2:0] == 3'h1 |=> port2Gpio == 8'h0f && port3Gpio == 8'h00)
    else $error("low share grant wrong");
  chk_dir_hold: assert property (!regWr |=> $stable(port2OutEn))
    else $error("enable moved without write");
endmodule

// ### bench/port_direction_pullup_ctrl_tb.sv
/*
  Self-checking bench of the port direction and pull-up block.
  Assumes the header, package, design and checker are compiled first.
*/
`timescale 1ns/10ps
`include "port_ctrl_consts.svh"
module port_direction_pullup_ctrl_tb;
  import port_ctrl_pkg::*;
  logic core_clk = 0, rstn = 0, regWr = 0, regRd = 0, rdPend = 0;
  byte_type regAddr = 8'h00, regWdata = 8'h00, drvData = 8'h00;
  byte_type regRdata, pinLevel, oe0, oe1, oe2, oe3, oe5;
  byte_type pu0, pu1, pu2, pu3, pu5, g2, g3;
  byte_type q [$];
  byte_type offs [11] = '{8'hb8, 8'hc1, 8'hc2, 8'hc3, 8'hc5, 8'he0,
    8'he1, 8'he2, 8'he3, 8'he5, 8'hc4};
  byte_type g2Tab [8] = '{8'h00, 8'h0f, 8'hff, 8'hff, 8'hff, 0, 0, 0};
  byte_type g3Tab [8] = '{8'h00, 8'h00, 8'h00, 8'h0f, 8'hff, 0, 0, 0};
  int n_fail = 0, total_checks = 0;
  always #2.5 core_clk = ~core_clk;
  port_direction_pullup_ctrl port_direction_pullup_ctrl_i (
    .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .port0OutEn(oe0), .port1OutEn(oe1),
    .port2OutEn(oe2), .port3OutEn(oe3), .port5OutEn(oe5),
    .port0PullEn(pu0), .port1PullEn(pu1), .port2PullEn(pu2),
    .port3PullEn(pu3), .port5PullEn(pu5), .port2Gpio(g2), .port3Gpio(g3)
  );
  port_pin_board port_pin_board_i (.core_clk(core_clk), .outEn(oe0),
    .pullEn(pu0), .drvData(drvData), .pinLevel(pinLevel));
  task automatic cmp_val(input byte_type got, input byte_type exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input byte_type a, input byte_type d);
    @(posedge core_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge core_clk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic rd(input byte_type a, input byte_type exp);
    @(posedge core_clk);
    regRd <= 1'b1;
    regAddr <= a;
    q.push_back(exp);
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask
  task automatic final_report();
    if (n_fail == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Read data lands one cycle after the strobe; match the oldest note
  always @(posedge core_clk) begin
    if (rdPend) cmp_val(regRdata, q.pop_front());
    rdPend <= regRd;
  end
  // Watchdog against a hung sequence
  initial begin
    #20000;
    n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    int b;
    byte_type e;
    b = $urandom(60898);
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp_val(pu1, 8'h00);
    foreach (offs[i]) rd(offs[i], 8'h00);
    wr(`OFF_PORT0_DIRECTION, 8'hff);
    cmp_val(oe0, 8'h17);
    rd(`OFF_PORT0_DIRECTION, 8'h17);
    wr(`OFF_PORT0_PULLUP, 8'hff);
    cmp_val(pu0, 8'h00);
    wr(`OFF_PORT0_DIRECTION, 8'h00);
    cmp_val(pu0, 8'h17);
    cmp_val(pinLevel & 8'h17, 8'h17);
    // Output pins follow the board-side drive data
    drvData <= b[7:0];
    wr(`OFF_PORT0_DIRECTION, 8'hff);
    cmp_val(pinLevel & 8'h17, b[7:0] & 8'h17);
    wr(`OFF_PORT0_DIRECTION, 8'h00);
    // Single-bit clear then set on a random port 1 pin
    wr(`OFF_PORT1_DIRECTION, 8'hff);
    b = $urandom_range(6, 0);
    wr(`OFF_BIT_OP, {1'b0, 4'd1, b[2:0]});
    cmp_val(oe1, 8'h7f & ~(8'h01 << b));
    wr(`OFF_BIT_OP, {1'b1, 4'd1, b[2:0]});
    cmp_val(oe1, 8'h7f);
    wr(`OFF_BIT_OP, {1'b1, 4'd0, 3'd3});
    cmp_val(oe0, 8'h00);
    // Port 5 pull-up, bit set, and an ignored register select
    wr(`OFF_PORT5_PULLUP, 8'hff);
    cmp_val(pu5, 8'h10);
    wr(`OFF_BIT_OP, {1'b1, 4'd4, 3'd4});
    cmp_val(oe5, 8'h10);
    cmp_val(pu5, 8'h00);
    wr(`OFF_BIT_OP, {1'b0, 4'd9, 3'd4});
    cmp_val(oe5, 8'h10);
    // Every share select value against its grant table
    e = $urandom;
    wr(`OFF_PORT3_DIRECTION, e);
    wr(`OFF_PORT2_PULLUP, 8'hff);
    wr(`OFF_PORT3_PULLUP, 8'hff);
    for (int s = 0; s < 8; s++) begin
      wr(`OFF_SEG_SHARE, s[7:0]);
      wr(`OFF_PORT2_DIRECTION, 8'h0f);
      cmp_val(g2, g2Tab[s]);
      cmp_val(oe2, 8'h0f & g2Tab[s]);
      cmp_val(pu2, 8'hf0 & g2Tab[s]);
      cmp_val(oe3, e & g3Tab[s]);
      cmp_val(g3, g3Tab[s]);
      cmp_val(pu3, ~e & g3Tab[s]);
    end
    rd(`OFF_PORT3_DIRECTION, e);
    rd(`OFF_SEG_SHARE, 8'h07);
    rd(`OFF_PORT2_PULLUP, 8'h00);
    // Reset in mid-run clears every register
    repeat (2) @(posedge core_clk);
    rstn <= 1'b0;
    repeat (2) @(posedge core_clk);
    cmp_val(oe1, 8'h00);
    cmp_val(pu0 | oe5, 8'h00);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    cmp_val(pu0, 8'h00);
    rd(`OFF_PORT5_DIRECTION, 8'h00);
    repeat (3) @(posedge core_clk);
    final_report();
  end
endmodule
bind port_direction_pullup_ctrl port_ctrl_checker port_ctrl_checker_i (
  .core_clk(core_clk), .rstn(rstn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
  .regRdata(regRdata), .port0OutEn(port0OutEn),
  .port0PullEn(port0PullEn), .port2OutEn(port2OutEn),
  .port2PullEn(port2PullEn), .port2Gpio(port2Gpio), .port3Gpio(port3Gpio)
);

// ### bench/port_pin_board.sv
/*
  Board-side model of one port's pins: resolves each pin's level.
  Assumes enables arrive from the block, drive data from the bench.
*/
`timescale 1ns/10ps
module port_pin_board (
  input wire logic core_clk,
  input wire logic [7:0] outEn,
  input wire logic [7:0] pullEn,
  input wire logic [7:0] drvData,
  output logic [7:0] pinLevel
);
  logic [7:0] floatPat = 8'h55;
  // Undriven, unpulled pins wander every cycle
  always @(posedge core_clk) floatPat <= ~floatPat;
  // Driven, pulled up, or floating
  assign pinLevel = (outEn & drvData) | (~outEn & pullEn) |
    (~outEn & ~pullEn & floatPat);
endmodule

// ### core/pin_cfg_if.sv
/*
  Carrier for per-port configuration between the register file and the
  pin-control stage.
  Assumes the package is compiled first.
*/
`timescale 1ns/10ps
interface pin_cfg_if;
  import port_ctrl_pkg::*;
  byte_type dir [5];
  byte_type pull [5];
  logic [7:0] gpioP2;
  logic [7:0] gpioP3;
  modport regs (output dir, output pull, output gpioP2, output gpioP3);
  modport pins (input dir, input pull, input gpioP2, input gpioP3);
endinterface

// ### core/pin_drive.sv
/*
  Turns direction, pull-up and share grants into pin enables.
  Assumes config arrives through pin_cfg_if in the core_clk domain.
*/
`timescale 1ns/10ps
module pin_drive
  import port_ctrl_pkg::*;
(
  pin_cfg_if.pins cfg,
  output logic [7:0] outEn [5],
  output logic [7:0] pullEn [5]
);
  logic [7:0] grant [5];
  // Ports 2 and 3 act as GPIO only where granted
  always_comb begin
    grant[0] = 8'hff;
    grant[1] = 8'hff;
    grant[2] = cfg.gpioP2;
    grant[3] = cfg.gpioP3;
    grant[4] = 8'hff;
  end
  // Pull-up only while the pin is an input
  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_port
      assign outEn[p] = cfg.dir[p] & grant[p];
      assign pullEn[p] = cfg.pull[p] & ~cfg.dir[p] & grant[p];
    end
  endgenerate
endmodule

// ### core/port_ctrl_consts.svh
/*
  Offsets, implemented-bit masks, field positions and reset values of the
  port direction and pull-up block.
  Assumes it is included by bare name; definitions only.
*/
`ifndef PORT_CTRL_CONSTS_SVH
`define PORT_CTRL_CONSTS_SVH

`define ADDR_W 8
`define DATA_W 8
`define OFF_PORT0_DIRECTION 8'hb8
`define OFF_PORT1_DIRECTION 8'hc1
`define OFF_PORT2_DIRECTION 8'hc2
`define OFF_PORT3_DIRECTION 8'hc3
`define OFF_PORT5_DIRECTION 8'hc5
`define OFF_PORT0_PULLUP 8'he0
`define OFF_PORT1_PULLUP 8'he1
`define OFF_PORT2_PULLUP 8'he2
`define OFF_PORT3_PULLUP 8'he3
`define OFF_PORT5_PULLUP 8'he5
`define OFF_SEG_SHARE 8'hc8
`define OFF_BIT_OP 8'hc9
`define MASK_PORT0 8'h17
`define MASK_PORT1 8'h7f
`define MASK_PORT2 8'hff
`define MASK_PORT3 8'hff
`define MASK_PORT5 8'h10
`define RST_DIRECTION 8'h00
`define RST_PULLUP 8'h00
`define RST_SEG_SHARE 3'h0
`define SEG_SHARE_W 3
`define BITOP_SET_POS 7
`define BITOP_REG_LSB 3
`define BITOP_REG_W 4
`define BITOP_BIT_LSB 0
`define BITOP_BIT_W 3
`define RO_ZERO 8'h00

`endif

// ### core/port_ctrl_pkg.sv
/*
  Types shared by the port direction and pull-up block.
  Assumes port_ctrl_consts.svh is on the include path.
*/
package port_ctrl_pkg;
  typedef enum logic [2:0] {
    SEG_NONE, SEG_P2LOW, SEG_P2ALL, SEG_P2P3LOW, SEG_ALL
  } seg_share_type;
  typedef logic [7:0] byte_type;
  typedef enum logic [3:0] {
    PSEL_DIR0, PSEL_DIR1, PSEL_DIR2, PSEL_DIR3, PSEL_DIR5,
    PSEL_PU0, PSEL_PU1, PSEL_PU2, PSEL_PU3, PSEL_PU5, PSEL_NONE
  } port_sel_type;
endpackage

// ### core/port_direction_pullup_ctrl.sv
/*
  Direction and pull-up registers of GPIO ports 0,1,2,3,5 with segment
  sharing for ports 2 and 3, reached over a plain register port.
  Assumes a single core_clk domain; strobes one cycle, never together.
*/
// The implementer's own choice: strobed register access.
// Operation
// - Direction bit 0 input, 1 output
// - Single-bit set and clear on direction
// - Port 0 bit 3 never an output
// - Pull-up bit 1 enables, 0 disables
// - Pull-up acts only in input mode
// - Port 0 bit 3 has no pull-up
// - Share select 4 frees ports 2, 3
`timescale 1ns/10ps
`include "port_ctrl_consts.svh"
module port_direction_pullup_ctrl
  import port_ctrl_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [`DATA_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`DATA_W-1:0] regRdata,
  output logic [7:0] port0OutEn,
  output logic [7:0] port1OutEn,
  output logic [7:0] port2OutEn,
  output logic [7:0] port3OutEn,
  output logic [7:0] port5OutEn,
  output logic [7:0] port0PullEn,
  output logic [7:0] port1PullEn,
  output logic [7:0] port2PullEn,
  output logic [7:0] port3PullEn,
  output logic [7:0] port5PullEn,
  output logic [7:0] port2Gpio,
  output logic [7:0] port3Gpio
);
  import port_ctrl_pkg::*;

  localparam byte_type MASKS [5] = '{`MASK_PORT0, `MASK_PORT1,
    `MASK_PORT2, `MASK_PORT3, `MASK_PORT5};

  logic rstSync1_ff;
  logic rstSync2_ff;
  logic rstnInt;
  byte_type dir_ff [5];
  byte_type pull_ff [5];
  logic [`SEG_SHARE_W-1:0] segShare_ff;
  byte_type regRdata_ff;
  port_sel_type sel;
  logic [2:0] selIdx;
  logic selIsDir;
  logic selIsPull;
  logic bitOpHit;
  logic bitOpSet;
  port_sel_type bitOpSel;
  logic [2:0] bitOpIdx;
  byte_type bitOpMask;
  byte_type rdMux;
  logic [7:0] outEnArr [5];
  logic [7:0] pullEnArr [5];

  pin_cfg_if cfg ();

  // Reset release through two flops
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rstSync1_ff <= 1'b0;
      rstSync2_ff <= 1'b0;
    end else begin
      rstSync1_ff <= 1'b1;
      rstSync2_ff <= rstSync1_ff;
    end
  end
  assign rstnInt = rstSync2_ff;

  // Address decode of the whole-register accesses
  always_comb begin
    unique case (regAddr)
      `OFF_PORT0_DIRECTION: sel = PSEL_DIR0;
      `OFF_PORT1_DIRECTION: sel = PSEL_DIR1;
      `OFF_PORT2_DIRECTION: sel = PSEL_DIR2;
      `OFF_PORT3_DIRECTION: sel = PSEL_DIR3;
      `OFF_PORT5_DIRECTION: sel = PSEL_DIR5;
      `OFF_PORT0_PULLUP: sel = PSEL_PU0;
      `OFF_PORT1_PULLUP: sel = PSEL_PU1;
      `OFF_PORT2_PULLUP: sel = PSEL_PU2;
      `OFF_PORT3_PULLUP: sel = PSEL_PU3;
      `OFF_PORT5_PULLUP: sel = PSEL_PU5;
      default: sel = PSEL_NONE;
    endcase
  end

  // Port index and register kind of the decoded select
  always_comb begin
    selIsDir = (sel <= PSEL_DIR5);
    selIsPull = (sel >= PSEL_PU0) && (sel <= PSEL_PU5);
    if (selIsDir) begin
      selIdx = 3'(sel);
    end else if (selIsPull) begin
      selIdx = 3'(sel - PSEL_PU0);
    end else begin
      selIdx = 3'h0;
    end
  end

  // Bit operation word: set flag, direction register, bit number
  always_comb begin
    bitOpHit = regWr && (regAddr == `OFF_BIT_OP);
    bitOpSet = regWdata[`BITOP_SET_POS];
    bitOpSel = port_sel_type'(
      regWdata[`BITOP_REG_LSB +: `BITOP_REG_W]);
    bitOpIdx = 3'(bitOpSel);
    bitOpMask = 8'h01 << regWdata[`BITOP_BIT_LSB +: `BITOP_BIT_W];
  end

  // Direction registers: whole writes and single-bit set or clear
  genvar p;
  generate
    for (p = 0; p < 5; p++) begin : g_dir
      always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
          dir_ff[p] <= `RST_DIRECTION;
        end else if (regWr && selIsDir && selIdx == 3'(p)) begin
          dir_ff[p] <= regWdata & MASKS[p];
        end else if (bitOpHit && bitOpSel <= PSEL_DIR5
                     && bitOpIdx == 3'(p)) begin
          if (bitOpSet) begin
            dir_ff[p] <= (dir_ff[p] | bitOpMask) & MASKS[p];
          end else begin
            dir_ff[p] <= dir_ff[p] & ~bitOpMask;
          end
        end
      end
    end
  endgenerate

  // Pull-up registers, write only from software
  generate
    for (p = 0; p < 5; p++) begin : g_pull
      always_ff @(posedge core_clk or negedge rstnInt) begin
        if (!rstnInt) begin
          pull_ff[p] <= `RST_PULLUP;
        end else if (regWr && selIsPull && selIdx == 3'(p)) begin
          pull_ff[p] <= regWdata & MASKS[p];
        end
      end
    end
  endgenerate

  // Segment-share select
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      segShare_ff <= `RST_SEG_SHARE;
    end else if (regWr && regAddr == `OFF_SEG_SHARE) begin
      segShare_ff <= regWdata[`SEG_SHARE_W-1:0];
    end
  end

  // Read mux: pull-ups and bit-op port read zero
  always_comb begin
    rdMux = `RO_ZERO;
    if (selIsDir) begin
      rdMux = dir_ff[selIdx];
    end else if (regAddr == `OFF_SEG_SHARE) begin
      rdMux = {5'h00, segShare_ff};
    end
  end

  // Read data stands in the cycle after the strobe only
  always_ff @(posedge core_clk or negedge rstnInt) begin
    if (!rstnInt) begin
      regRdata_ff <= 8'h00;
    end else if (regRd) begin
      regRdata_ff <= rdMux;
    end else begin
      regRdata_ff <= 8'h00;
    end
  end
  assign regRdata = regRdata_ff;

  // Configuration onto the carrier
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      cfg.dir[i] = dir_ff[i];
      cfg.pull[i] = pull_ff[i];
    end
  end

  seg_share_decode u_seg (
    .segSel(segShare_ff),
    .gpioP2(cfg.gpioP2),
    .gpioP3(cfg.gpioP3)
  );

  pin_drive u_drive (
    .cfg(cfg.pins),
    .outEn(outEnArr),
    .pullEn(pullEnArr)
  );

  // Pin control outputs
  assign port0OutEn = outEnArr[0];
  assign port1OutEn = outEnArr[1];
  assign port2OutEn = outEnArr[2];
  assign port3OutEn = outEnArr[3];
  assign port5OutEn = outEnArr[4];
  assign port0PullEn = pullEnArr[0];
  assign port1PullEn = pullEnArr[1];
  assign port2PullEn = pullEnArr[2];
  assign port3PullEn = pullEnArr[3];
  assign port5PullEn = pullEnArr[4];
  assign port2Gpio = cfg.gpioP2;
  assign port3Gpio = cfg.gpioP3;
endmodule

// ### core/seg_share_decode.sv
/*
  Decodes the segment-share select into per-pin GPIO grants of ports 2, 3.
  Assumes a registered select value at its input.
*/
`timescale 1ns/10ps
`include "port_ctrl_consts.svh"
module seg_share_decode
  import port_ctrl_pkg::*;
(
  input wire logic [`SEG_SHARE_W-1:0] segSel,
  output logic [7:0] gpioP2,
  output logic [7:0] gpioP3
);
  // Groups freed step by step as the select value grows to 4; values 5 to 7 free none
  always_comb begin
    gpioP2 = 8'h00;
    gpioP3 = 8'h00;
    unique case (segSel)
      3'h1: gpioP2 = 8'h0f;
      3'h2: gpioP2 = 8'hff;
      3'h3: begin
        gpioP2 = 8'hff;
        gpioP3 = 8'h0f;
      end
      3'h4: begin
        gpioP2 = 8'hff;
        gpioP3 = 8'hff;
      end
      default: begin
        gpioP2 = 8'h00;
        gpioP3 = 8'h00;
      end
    endcase
  end
endmodule
